//--- rtl/iface_clock_gen.sv
// Phase accumulator that derives the interface clock from the reference clock.
module iface_clock_gen #(
    parameter int ACC_W = 24
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [ACC_W-1:0] step,
    output logic clkOut
);

    // Whole state of the generator.
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic clkOut;
    } gen_s;

    gen_s r;
    gen_s next_r;
    logic [ACC_W:0] sum;

    // Toggle on each accumulator carry; low when stopped.
    always_comb
    begin
        next_r = r;
        sum = {1'b0, r.acc} + {1'b0, step};
        if (!run)
        begin
            next_r.acc = '0;
            next_r.clkOut = 1'b0;
        end
        else
        begin
            next_r.acc = sum[ACC_W-1:0];
            next_r.clkOut = r.clkOut ^ sum[ACC_W];
        end
    end

    // Register the state.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign clkOut = r.clkOut;

endmodule

//--- rtl/link_power_monitor.sv
// Link power status monitor with its APB registers and link-facing outputs.
//
// Contract
// - Sense inactive after about 2.6 us low.
// - Sense lost: reset state, outputs zero, request ignored.
// - Low about 26 us: disabled, clock stopped.
// - Report link active: sense active and bit set.
// - Sample power-class straps at hardware reset.
// - Wide mode: interface clock 98.304 MHz.
// - Narrow mode: interface clock 49.152 MHz.
// - Power-down stops all but cable-activity monitor.
// - Power-down forces internal control reset.
// - Wide mode sends status serially on output.
module link_power_monitor #(
    parameter int DISABLE_CYCLES = link_power_pkg::SENSE_DISABLE_CYCLES,
    parameter int RESET_CYCLES = link_power_pkg::SENSE_RESET_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link side inputs.
    input wire logic linkPowerSense,
    input wire logic linkRequestIn,
    input wire logic powerClassStrap0,
    input wire logic powerClassStrap1,
    input wire logic powerClassStrap2,
    input wire logic powerDownIn,
    input wire logic wideInterfaceModeSelect,
    // Device side sources.
    input wire logic cableActivityIn,
    input wire logic [1:0] coreControl,
    input wire logic [7:0] coreData,
    // Link side outputs.
    output logic [1:0] interfaceControlLines,
    output logic [7:0] interfaceData,
    output logic interfaceClock,
    output logic serialStatusOut,
    output logic cableActivityOut,
    // Device side outputs.
    output logic linkRequestOut,
    output logic linkReportedActive,
    output logic [2:0] powerClass,
    output logic coreShutdown,
    output logic irq
);

    // Whole state of the monitor.
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic linkActive;
        logic [2:0] powerClass;
        logic strapsTaken;
        logic [link_power_pkg::IRQ_W-1:0] irqStatus;
        logic [link_power_pkg::IRQ_W-1:0] irqEnable;
        link_power_pkg::if_state_e ifState;
        logic [1:0] ctl;
        logic [7:0] data;
        logic linkReq;
        logic cableActive;
        logic linkReported;
        logic [link_power_pkg::FRAME_W-1:0] shift;
        logic [link_power_pkg::COUNT_W-1:0] shiftCount;
        logic [7:0] lastSent;
        logic serialOut;
        logic coreShutdown;
        logic irq;
    } mon_s;

    mon_s r;
    mon_s next_r;

    // Low-time detector outputs.
    logic senseResetHit;
    logic senseDisableHit;
    // Counters restart on high sense or power-down.
    logic counterClear;
    // Interface clock enable and rate.
    logic clockRun;
    logic [link_power_pkg::ACC_W-1:0] clockStep;
    // Status payload for the serial frame.
    logic [7:0] payload;
    // Bus strobes for the completing access.
    logic doAccess;
    logic doWrite;

    // Restart on any high sense sample.
    assign counterClear = linkPowerSense | powerDownIn;
    // Clock stops when disabled or powered down.
    assign clockRun = (r.ifState != link_power_pkg::IF_DISABLED) && !powerDownIn;
    // Rate is picked by the interface mode pin.
    assign clockStep = wideInterfaceModeSelect ? link_power_pkg::STEP_WIDE
                                               : link_power_pkg::STEP_NARROW;

    // Detector for the reset threshold.
    low_time_counter #(
        .LIMIT(RESET_CYCLES),
        .WIDTH(16)
    ) resetCounter (
        .clk(clk),
        .rstn(rstn),
        .clear(counterClear),
        .expired(senseResetHit)
    );

    // Detector for the disable threshold.
    low_time_counter #(
        .LIMIT(DISABLE_CYCLES),
        .WIDTH(16)
    ) disableCounter (
        .clk(clk),
        .rstn(rstn),
        .clear(counterClear),
        .expired(senseDisableHit)
    );

    // Interface clock generator.
    iface_clock_gen #(
        .ACC_W(link_power_pkg::ACC_W)
    ) clockGen (
        .clk(clk),
        .rstn(rstn),
        .run(clockRun),
        .step(clockStep),
        .clkOut(interfaceClock)
    );

    // Serial payload: status bits, state and flags.
    assign payload = {r.irqStatus, r.ifState, r.linkReported, ~senseResetHit, 1'b0};

    // An access completes when ready is already up.
    assign doAccess = psel && penable && r.pready;
    assign doWrite = doAccess && pwrite;

    // Next-state logic for the whole monitor.
    always_comb
    begin
        next_r = r;

        // Cable activity is followed even in power-down.
        next_r.cableActive = cableActivityIn;

        // Bus answer: ready rises one cycle into the access phase.
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = 1'b0;
        next_r.prdata = '0;
        if (psel && penable && !r.pready)
        begin
            // Address decode for read data and the error answer.
            if (paddr == link_power_pkg::ADDR_CONTROL)
            begin
                next_r.prdata[link_power_pkg::CTRL_LINK_ACTIVE] = r.linkActive;
            end
            else if (paddr == link_power_pkg::ADDR_STATE)
            begin
                next_r.prdata[link_power_pkg::STATE_IF_LSB +: 2] = r.ifState;
                next_r.prdata[link_power_pkg::STATE_SENSE] = ~senseResetHit;
                next_r.prdata[link_power_pkg::STATE_REPORTED] = r.linkReported;
                next_r.prdata[link_power_pkg::STATE_CLASS_LSB +: 3] = r.powerClass;
                next_r.prdata[link_power_pkg::STATE_WIDE] = wideInterfaceModeSelect;
            end
            else if (paddr == link_power_pkg::ADDR_IRQ_STATUS)
            begin
                next_r.prdata[link_power_pkg::IRQ_W-1:0] = r.irqStatus;
            end
            else if (paddr == link_power_pkg::ADDR_IRQ_CLEAR)
            begin
                // Write-only register reads as zero.
                next_r.prdata = '0;
            end
            else if (paddr == link_power_pkg::ADDR_IRQ_ENABLE)
            begin
                next_r.prdata[link_power_pkg::IRQ_W-1:0] = r.irqEnable;
            end
            else if (paddr == link_power_pkg::ADDR_POWER_CLASS)
            begin
                next_r.prdata[2:0] = r.powerClass;
            end
            else
            begin
                // Unmapped address answers with an error.
                next_r.pslverr = 1'b1;
            end
        end

        // Register writes take effect on the completing edge.
        if (doWrite)
        begin
            if (paddr == link_power_pkg::ADDR_CONTROL)
            begin
                next_r.linkActive = pwdata[link_power_pkg::CTRL_LINK_ACTIVE];
            end
            else if (paddr == link_power_pkg::ADDR_IRQ_CLEAR)
            begin
                next_r.irqStatus = r.irqStatus & ~pwdata[link_power_pkg::IRQ_W-1:0];
            end
            else if (paddr == link_power_pkg::ADDR_IRQ_ENABLE)
            begin
                next_r.irqEnable = pwdata[link_power_pkg::IRQ_W-1:0];
            end
            else if (paddr == link_power_pkg::ADDR_POWER_CLASS)
            begin
                next_r.powerClass = pwdata[2:0];
            end
            else
            begin
                // Other addresses hold nothing writable.
                next_r.linkActive = r.linkActive;
            end
        end

        // Straps are caught on the first edge after reset.
        if (!r.strapsTaken)
        begin
            next_r.strapsTaken = 1'b1;
            next_r.powerClass = {powerClassStrap2, powerClassStrap1,
                powerClassStrap0};
        end

        // Interface state follows the low-time detectors.
        case (r.ifState)
            link_power_pkg::IF_ACTIVE:
            begin
                if (senseResetHit)
                begin
                    next_r.ifState = link_power_pkg::IF_RESET;
                    next_r.irqStatus[link_power_pkg::IRQ_SENSE_LOST] = 1'b1;
                end
            end
            link_power_pkg::IF_RESET:
            begin
                if (!senseResetHit)
                begin
                    next_r.ifState = link_power_pkg::IF_ACTIVE;
                    next_r.irqStatus[link_power_pkg::IRQ_RESTORED] = 1'b1;
                end
                else if (senseDisableHit)
                begin
                    next_r.ifState = link_power_pkg::IF_DISABLED;
                    next_r.irqStatus[link_power_pkg::IRQ_DISABLED] = 1'b1;
                end
            end
            link_power_pkg::IF_DISABLED:
            begin
                if (!senseResetHit)
                begin
                    next_r.ifState = link_power_pkg::IF_ACTIVE;
                    next_r.irqStatus[link_power_pkg::IRQ_RESTORED] = 1'b1;
                end
            end
            default:
            begin
                next_r.ifState = link_power_pkg::IF_RESET;
            end
        endcase

        // Link outputs zero and requests dropped unless active.
        if (r.ifState == link_power_pkg::IF_ACTIVE && !senseResetHit)
        begin
            next_r.ctl = coreControl;
            next_r.data = coreData;
            next_r.linkReq = linkRequestIn;
        end
        else
        begin
            next_r.ctl = '0;
            next_r.data = '0;
            next_r.linkReq = 1'b0;
        end

        // Self-ID link state needs active sense and the control bit.
        next_r.linkReported = !senseResetHit && r.linkActive;

        // Serial status sender, only in wide mode.
        if (!wideInterfaceModeSelect)
        begin
            next_r.shiftCount = '0;
            next_r.serialOut = 1'b0;
            next_r.lastSent = '0;
        end
        else if (r.shiftCount != '0)
        begin
            next_r.serialOut = r.shift[link_power_pkg::FRAME_W-1];
            next_r.shift = {r.shift[link_power_pkg::FRAME_W-2:0], 1'b0};
            next_r.shiftCount = r.shiftCount - 1'b1;
        end
        else if (payload != r.lastSent)
        begin
            next_r.serialOut = 1'b0;
            next_r.shift = {link_power_pkg::FRAME_START, payload};
            next_r.shiftCount = link_power_pkg::COUNT_W'(link_power_pkg::FRAME_W);
            next_r.lastSent = payload;
        end
        else
        begin
            next_r.serialOut = 1'b0;
        end

        // One level interrupt from enabled sticky bits.
        next_r.irq = |(next_r.irqStatus & next_r.irqEnable);
        next_r.coreShutdown = 1'b0;

        // Power-down resets all control state except cable activity.
        if (powerDownIn)
        begin
            next_r = '0;
            next_r.ifState = link_power_pkg::IF_RESET;
            next_r.cableActive = cableActivityIn;
            next_r.coreShutdown = 1'b1;
        end
    end

    // Register the state; reset loads constants only.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
            r.linkActive <= link_power_pkg::CTRL_LINK_ACTIVE_RESET;
            r.irqStatus <= link_power_pkg::IRQ_RESET;
            r.ifState <= link_power_pkg::IF_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register.
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign interfaceControlLines = r.ctl;
    assign interfaceData = r.data;
    assign serialStatusOut = r.serialOut;
    assign cableActivityOut = r.cableActive;
    assign linkRequestOut = r.linkReq;
    assign linkReportedActive = r.linkReported;
    assign powerClass = r.powerClass;
    assign coreShutdown = r.coreShutdown;
    assign irq = r.irq;

endmodule

//--- rtl/link_power_pkg.sv
// Constants, register map and types shared by the link power status monitor.
package link_power_pkg;

    // Register byte addresses on the APB slave.
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_POWER_CLASS = 8'h14;

    // Control register field: the link-active bit.
    localparam int CTRL_LINK_ACTIVE = 0;
    localparam logic CTRL_LINK_ACTIVE_RESET = 1'b0;

    // State register field positions.
    localparam int STATE_IF_LSB = 0;
    localparam int STATE_SENSE = 2;
    localparam int STATE_REPORTED = 3;
    localparam int STATE_CLASS_LSB = 4;
    localparam int STATE_WIDE = 7;

    // Interrupt event bit positions and width.
    localparam int IRQ_W = 3;
    localparam int IRQ_SENSE_LOST = 0;
    localparam int IRQ_DISABLED = 1;
    localparam int IRQ_RESTORED = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // Clock period and sense thresholds in their own units.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SENSE_RESET_NS = 2600;
    localparam int SENSE_DISABLE_NS = 26000;
    // Least times round up to whole cycles.
    localparam int SENSE_RESET_CYCLES =
        (SENSE_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SENSE_DISABLE_CYCLES =
        (SENSE_DISABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Interface clock rates in kHz and the accumulator step added per reference clock cycle.
    localparam int ACC_W = 24;
    localparam longint CLK_KHZ = 200000;
    localparam longint WIDE_KHZ = 98304;
    localparam longint NARROW_KHZ = 49152;
    localparam logic [ACC_W-1:0] STEP_WIDE = ACC_W'(((2 * WIDE_KHZ) << ACC_W) / CLK_KHZ);
    localparam logic [ACC_W-1:0] STEP_NARROW = ACC_W'(((2 * NARROW_KHZ) << ACC_W) / CLK_KHZ);

    // Serial status frame: one start bit and eight payload bits.
    localparam int FRAME_W = 9;
    localparam logic FRAME_START = 1'b1;
    localparam int COUNT_W = 4;

    // State of the link-facing interface.
    typedef enum logic [1:0] {IF_ACTIVE, IF_RESET, IF_DISABLED} if_state_e;

endpackage

//--- rtl/low_time_counter.sv
// Counter that flags when an input has stayed low for a number of cycles.
module low_time_counter #(
    parameter int LIMIT = 520,
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    output logic expired
);

    // Whole state of the counter.
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic expired;
    } cnt_s;

    cnt_s r;
    cnt_s next_r;

    // Restart on clear, otherwise count up and saturate at the limit.
    always_comb
    begin
        next_r = r;
        if (clear)
        begin
            next_r.count = '0;
            next_r.expired = 1'b0;
        end
        else if (r.count < WIDTH'(LIMIT))
        begin
            next_r.count = r.count + 1'b1;
        end
        else
        begin
            next_r.expired = 1'b1;
        end
    end

    // Register the state.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign expired = r.expired;

endmodule

//--- sim/link_layer_model.sv
// Behavioural link-layer controller driving the sense and request lines.
module link_layer_model (
    input wire logic clk,
    input wire logic [1:0] senseMode,
    input wire logic [3:0] lowLen,
    input wire logic wantRequest,
    output logic linkPowerSense = 1'b0,
    output logic linkRequestIn = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // High phase of 25 ns, enough for the device to see it.
    localparam logic [3:0] HIGH_LEN = 4'h5;
    // Position within one sense pulse period.
    logic [3:0] phase = 4'h0;

    // Mode 0 leaves sense low, 1 holds it high, 2 sends pulses.
    always @(posedge clk)
    begin
        linkRequestIn <= wantRequest;
        phase <= (phase >= HIGH_LEN + lowLen - 4'h1) ? 4'h0 : phase + 4'h1;
        case (senseMode)
            2'h1: linkPowerSense <= 1'b1;
            2'h2: linkPowerSense <= (phase < HIGH_LEN);
            default: linkPowerSense <= 1'b0;
        endcase
    end
endmodule

//--- sim/link_power_checker_monitor.sv
// Port assertions for the link power monitor.
module link_power_checker #(
    parameter int DISABLE_CYCLES = 40,
    parameter int RESET_CYCLES = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic linkPowerSense,
    input wire logic powerDownIn,
    input wire logic cableActivityIn,
    input wire logic [1:0] interfaceControlLines,
    input wire logic [7:0] interfaceData,
    input wire logic interfaceClock,
    input wire logic linkRequestOut,
    input wire logic linkReportedActive,
    input wire logic cableActivityOut,
    input wire logic coreShutdown,
    input wire logic serialStatusOut,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // Low runs that force each state, with slack for detector delay.
    localparam int RT = RESET_CYCLES + 4;
    localparam int DT = DISABLE_CYCLES + 4;
    // Low sense samples since high sense or power-down.
    logic [7:0] lowCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Saturating count of the low run.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lowCnt <= 8'h00;
        else if (linkPowerSense || powerDownIn)
            lowCnt <= 8'h00;
        else if (lowCnt != 8'hff)
            lowCnt <= lowCnt + 8'h01;
    end

    chk_iface_held:
        assert property (int'(lowCnt) >= RT |-> interfaceControlLines == 2'b00
            && interfaceData == 8'h00) else $error("link outputs not held low");
    chk_req_ignored:
        assert property (int'(lowCnt) >= RT |-> !linkRequestOut)
        else $error("request passed in reset state");
    chk_report_off:
        assert property (int'(lowCnt) >= RT |-> !linkReportedActive)
        else $error("link reported active without sense");
    chk_clock_off:
        assert property (int'(lowCnt) >= DT |-> !interfaceClock)
        else $error("clock not stopped when disabled");
    chk_clock_runs:
        assert property (disable iff (!rstn || powerDownIn)
            (int'(lowCnt) < DISABLE_CYCLES - 4)[*4] |-> ##[0:3] $changed(interfaceClock))
        else $error("interface clock not running");
    chk_pd_shutdown:
        assert property (powerDownIn |=> coreShutdown && !interfaceClock)
        else $error("core not shut off in power-down");
    chk_pd_reset:
        assert property (powerDownIn |=> !irq && !linkRequestOut && !serialStatusOut
            && interfaceData == 8'h00) else $error("power-down did not reset control");
    chk_cable_live:
        assert property (powerDownIn [*2] |-> cableActivityOut == $past(cableActivityIn))
        else $error("cable activity not passed in power-down");
endmodule

//--- sim/link_power_status_monitor_test.sv
// Self-checking testbench of the link power monitor.
module link_power_status_monitor_test;
    timeunit 1ns;
    timeprecision 100ps;
    // Shortened low-time counts keep the run brief.
    localparam int RCYC = 8;
    localparam int DCYC = 40;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, linkPowerSense, linkRequestIn;
    logic [2:0] strap = 3'h5;
    logic powerDownIn = 1'b0;
    logic wide = 1'b0;
    logic cableIn = 1'b0;
    logic [1:0] coreControl = 2'h0;
    logic [7:0] coreData = 8'h00;
    logic [1:0] ctrlOut;
    logic [7:0] dataOut;
    logic [2:0] powerClass;
    logic interfaceClock, serialStatusOut, cableOut, linkRequestOut, reported, shutdown, irq;
    logic [1:0] senseMode = 2'h1;
    logic wantRequest = 1'b0;
    int error_cnt = 0;
    int checks = 0;

    link_power_monitor #(.DISABLE_CYCLES(DCYC), .RESET_CYCLES(RCYC)) DUT (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .linkPowerSense(linkPowerSense), .linkRequestIn(linkRequestIn),
        .powerClassStrap0(strap[0]), .powerClassStrap1(strap[1]), .powerClassStrap2(strap[2]),
        .powerDownIn(powerDownIn), .wideInterfaceModeSelect(wide), .cableActivityIn(cableIn),
        .coreControl(coreControl), .coreData(coreData), .interfaceControlLines(ctrlOut),
        .interfaceData(dataOut), .interfaceClock(interfaceClock),
        .serialStatusOut(serialStatusOut), .cableActivityOut(cableOut),
        .linkRequestOut(linkRequestOut), .linkReportedActive(reported),
        .powerClass(powerClass), .coreShutdown(shutdown), .irq(irq));

    link_layer_model peer (.clk(clk), .senseMode(senseMode), .lowLen(4'h6),
        .wantRequest(wantRequest), .linkPowerSense(linkPowerSense),
        .linkRequestIn(linkRequestIn));

    // Free-running 200 MHz reference clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Counts interface clock changes over n cycles.
    task automatic toggles(input int n, output int t);
        logic last;
        last = interfaceClock;
        t = 0;
        repeat (n)
        begin
            @(posedge clk);
            t += int'(interfaceClock !== last);
            last = interfaceClock;
        end
    endtask

    // Register defaults, strap sampling and an unmapped access.
    task automatic t_reset_values();
        check(powerClass, 3'h5);
        apb(1'b0, link_power_pkg::ADDR_POWER_CLASS, 0);
        check(rd[2:0], 3'h5);
        apb(1'b0, link_power_pkg::ADDR_CONTROL, 0);
        check(rd, 0);
        apb(1'b0, link_power_pkg::ADDR_IRQ_ENABLE, 0);
        check(rd, 0);
        apb(1'b0, 8'h18, 0);
        check(err, 1'b1);
        check(rd, 0);
        $display("test reset_values done");
    endtask

    // Average clock rate in narrow then wide mode: 1000 cycles x 2 x fout / 200 MHz.
    task automatic t_clock_rate();
        int t, e;
        for (int m = 0; m < 2; m++)
        begin
            wide <= m[0];
            tick(8);
            toggles(1000, t);
            e = m ? 983 : 491;
            check(32'(t >= e - 2 && t <= e + 2), 1);
        end
        $display("test clock_rate done");
    endtask

    // Short low phases keep the interface active.
    task automatic t_sense_pulsed();
        senseMode <= 2'h2;
        wantRequest <= 1'b1;
        coreData <= 8'ha5;
        coreControl <= 2'h2;
        tick(60);
        check({linkRequestOut, ctrlOut, dataOut}, {1'b1, 2'h2, 8'ha5});
        apb(1'b0, link_power_pkg::ADDR_IRQ_STATUS, 0);
        check(rd[0], 1'b0);
        $display("test sense_pulsed done");
    endtask

    // Wide mode frame after the link-active bit is set.
    task automatic t_serial();
        logic [7:0] bits;
        senseMode <= 2'h1;
        apb(1'b1, link_power_pkg::ADDR_IRQ_CLEAR, 32'h7);
        tick(30);
        apb(1'b1, link_power_pkg::ADDR_CONTROL, 32'h1);
        while (serialStatusOut !== 1'b1)
            @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            bits = {bits[6:0], serialStatusOut};
        end
        check(bits, 8'h06);
        check(reported, 1'b1);
        $display("test serial done");
    endtask

    // Sense loss, disable, restore and the interrupt path.
    task automatic t_sense_lost();
        int t;
        apb(1'b1, link_power_pkg::ADDR_IRQ_ENABLE, 32'h7);
        senseMode <= 2'h0;
        tick(16);
        check({ctrlOut, dataOut, linkRequestOut}, 0);
        check({reported, irq}, 2'b01);
        toggles(20, t);
        check(32'(t > 0), 1);
        tick(30);
        toggles(20, t);
        check({t, interfaceClock}, 0);
        apb(1'b0, link_power_pkg::ADDR_STATE, 0);
        check(rd[1:0], 2'(link_power_pkg::IF_DISABLED));
        apb(1'b0, link_power_pkg::ADDR_IRQ_STATUS, 0);
        check(rd[2:0], 3'h3);
        apb(1'b1, link_power_pkg::ADDR_IRQ_CLEAR, 32'h3);
        check(irq, 1'b0);
        senseMode <= 2'h1;
        tick(10);
        apb(1'b0, link_power_pkg::ADDR_IRQ_STATUS, 0);
        check({irq, rd[2:0]}, 4'hc);
        apb(1'b1, link_power_pkg::ADDR_IRQ_ENABLE, 0);
        tick(2);
        check(irq, 1'b0);
        apb(1'b1, link_power_pkg::ADDR_IRQ_CLEAR, 32'h4);
        apb(1'b0, link_power_pkg::ADDR_IRQ_STATUS, 0);
        check(rd[2:0], 3'h0);
        $display("test sense_lost done");
    endtask

    // Power-down keeps cable activity and resets control.
    task automatic t_power_down();
        apb(1'b1, link_power_pkg::ADDR_POWER_CLASS, 32'h2);
        check(powerClass, 3'h2);
        strap <= 3'h3;
        cableIn <= 1'b1;
        powerDownIn <= 1'b1;
        tick(3);
        check({shutdown, interfaceClock, cableOut}, 3'b101);
        cableIn <= 1'b0;
        tick(2);
        check(cableOut, 1'b0);
        powerDownIn <= 1'b0;
        tick(3);
        check(powerClass, 3'h3);
        apb(1'b0, link_power_pkg::ADDR_CONTROL, 0);
        check(rd, 0);
        $display("test power_down done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence after a 20-cycle reset.
    initial
    begin
        tick(20);
        rstn <= 1'b1;
        tick(10);
        t_reset_values();
        t_clock_rate();
        t_sense_pulsed();
        t_serial();
        t_sense_lost();
        t_power_down();
        end_of_test();
    end

    // Cuts a hang short well beyond the expected run.
    initial
    begin
        tick(20000);
        error_cnt++;
        end_of_test();
    end
endmodule

bind link_power_monitor link_power_checker #(.DISABLE_CYCLES(DISABLE_CYCLES),
    .RESET_CYCLES(RESET_CYCLES)) mon (.clk(clk), .rstn(rstn),
    .linkPowerSense(linkPowerSense), .powerDownIn(powerDownIn),
    .cableActivityIn(cableActivityIn), .interfaceControlLines(interfaceControlLines),
    .interfaceData(interfaceData), .interfaceClock(interfaceClock),
    .linkRequestOut(linkRequestOut), .linkReportedActive(linkReportedActive),
    .cableActivityOut(cableActivityOut), .coreShutdown(coreShutdown),
    .serialStatusOut(serialStatusOut), .irq(irq));
